// File: design/dbfc_cfg.svh
// Purpose: constants of the DRAM-backed bit-serial FIFO controller
// Assumes: 100 MHz controller clock
// Notes:   timing counts derive from times in ns and the clock period
// Operation
// - keep 20-bit write pointer and 20-bit read pointer
// - one identity compare of all pointer bits gives full and empty
// - equal after a write means full; writes stall until a read
// - equal after a read means empty; reads stall until a write
// - only one memory access at a time on the single port
// - pointers are 20-bit LFSR counters, period two to twentieth minus one
// - both pointers use identical feedback and the same sequence
// - alternate pointer bits drive the 10-bit address, no multiplexer
// - row address before the shift, column address after it
// - refresh by CAS-before-RAS using the memory's own row counter
// - asynchronous user requests are synchronised before any cycle
`ifndef DBFC_CFG_SVH
`define DBFC_CFG_SVH
`define DBFC_PTR_W        20
`define DBFC_ADDR_W       10
`define DBFC_SEED         20'h00001
`define DBFC_TAP_HI       19
`define DBFC_TAP_LO       16
`define DBFC_CLK_NS       10
`define DBFC_T_PHASE_NS   30
`define DBFC_PHASE_CYC    ((`DBFC_T_PHASE_NS + `DBFC_CLK_NS - 1) / `DBFC_CLK_NS)
`define DBFC_T_REF_NS     15600
`define DBFC_REF_CYC      (`DBFC_T_REF_NS / `DBFC_CLK_NS)
`define DBFC_BUF_DEPTH    2
`endif

// File: design/dbfc_pkg.sv
// Purpose: types of the DRAM-backed FIFO controller
// Assumes: nothing
// Notes:   memory sequencer states
package dbfc_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ROW  = 3'b001,
      ST_COL  = 3'b010,
      ST_PRE  = 3'b011,
      ST_RCAS = 3'b100,
      ST_RRAS = 3'b101
   } dbfc_state_t;
endpackage : dbfc_pkg

// File: design/dbfc_buf.sv
// Purpose: small valid/ready buffer in the write data path
// Assumes: DEPTH a power of two, at least 2
// Notes:   full and empty are exact; in_ready drops when full
`timescale 1ns/1ns
module dbfc_buf #(
   parameter int W     = 1,
   parameter int DEPTH = 2
) (
   input  wire logic         clk,       // controller clock
   input  wire logic         rstn,      // async reset, active low
   input  wire logic         in_valid,  // producer offers a word
   output logic              in_ready,  // buffer has room
   input  wire logic [W-1:0] in_data,   // offered word
   output logic              out_valid, // buffer holds a word
   input  wire logic         out_ready, // consumer takes the word
   output logic      [W-1:0] out_data   // oldest word
);
   localparam int AW = (DEPTH > 2) ? $clog2(DEPTH) : 1;
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("dbfc_buf: DEPTH must be a power of two, at least 2");
   end
   logic [W-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wp_ff;
   logic [AW-1:0] rp_ff;
   logic [AW:0]   cnt_ff;
   logic          push;
   logic          pop;

   // compare at the counter's own width so DEPTH is not cut to zero
   assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
   assign out_valid = (cnt_ff != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_ff[rp_ff];

   always_ff @(posedge clk) begin
      if (push) begin
         mem_ff[wp_ff] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wp_ff  <= '0;
         rp_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) begin
            wp_ff <= wp_ff + AW'(1);
         end
         if (pop) begin
            rp_ff <= rp_ff + AW'(1);
         end
         if (push && !pop) begin
            cnt_ff <= cnt_ff + (AW+1)'(1);
         end else if (pop && !push) begin
            cnt_ff <= cnt_ff - (AW+1)'(1);
         end
      end
   end
endmodule : dbfc_buf

// File: design/dbfc_top.sv
// Purpose: controller that makes a single-port DRAM a deep bit FIFO
// Assumes: user requests are 4-phase req/ack, data stable while req high
// Notes:   one DRAM cycle at a time; refresh is CAS-before-RAS
`timescale 1ns/1ns
`include "dbfc_cfg.svh"
module dbfc_top #(
   parameter int PTR_W     = `DBFC_PTR_W,
   parameter int ADDR_W    = `DBFC_ADDR_W,
   parameter int PHASE_CYC = `DBFC_PHASE_CYC,
   parameter int REF_CYC   = `DBFC_REF_CYC,
   parameter int BUF_DEPTH = `DBFC_BUF_DEPTH
) (
   input  wire logic              clk,      // 100 MHz clock
   input  wire logic              rstn,     // async reset, active low
   input  wire logic              wr_req,   // async write request level
   input  wire logic              wr_data,  // bit to write
   output logic                   wr_ack,   // write taken
   input  wire logic              rd_req,   // async read request level
   output logic                   rd_ack,   // read data valid
   output logic                   rd_data,  // bit read
   output logic                   full,     // fifo full
   output logic                   empty,    // fifo empty
   output logic      [ADDR_W-1:0] dram_addr, // multiplexed address
   output logic                   ras_n,    // row strobe, active low
   output logic                   cas_n,    // column strobe, active low
   output logic                   we_n,     // write enable, active low
   output logic                   dram_d,   // data into memory
   input  wire logic              dram_q    // data from memory
);
   if (PTR_W != 20 || ADDR_W * 2 != PTR_W || PHASE_CYC < 1 ||
       PHASE_CYC > 15 || REF_CYC < 16 || REF_CYC > 4095) begin : g_chk
      $error("dbfc_top: unsupported parameter values");
   end

   dbfc_pkg::dbfc_state_t st_ff;
   dbfc_pkg::dbfc_state_t nxt_st;
   logic [PTR_W-1:0]  wptr_ff;
   logic [PTR_W-1:0]  rptr_ff;
   logic [PTR_W-1:0]  act_ptr;
   logic [PTR_W-1:0]  act_shift;
   logic [ADDR_W-1:0] row_addr;
   logic [ADDR_W-1:0] col_addr;
   logic              last_wr_ff;
   logic              act_wr_ff;
   logic              ptr_eq;
   logic [3:0]        pc_ff;
   logic              pc_done;
   logic [11:0]       ref_cnt_ff;
   logic              ref_pend_ff;
   logic [1:0]        wr_sync_ff;
   logic [1:0]        rd_sync_ff;
   logic              wr_ack_ff;
   logic              rd_ack_ff;
   logic              rd_data_ff;
   logic              rd_busy_ff;
   logic              buf_in_valid;
   logic              buf_in_ready;
   logic              buf_out_valid;
   logic              buf_out_ready;
   logic              buf_out_data;
   logic              grant_ref;
   logic              grant_wr;
   logic              grant_rd;
   logic              step_col;
   logic [ADDR_W-1:0] addr_ff;
   logic              ras_n_ff;
   logic              cas_n_ff;
   logic              we_n_ff;
   logic              dram_d_ff;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_sync_ff <= 2'h0;
         rd_sync_ff <= 2'h0;
      end else begin
         wr_sync_ff <= {wr_sync_ff[0], wr_req};
         rd_sync_ff <= {rd_sync_ff[0], rd_req};
      end
   end

   // write handshake pushes into the buffer, stalls ack when it is full
   assign buf_in_valid = wr_sync_ff[1] && !wr_ack_ff;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_ack_ff <= 1'b0;
      end else if (buf_in_valid && buf_in_ready) begin
         wr_ack_ff <= 1'b1;
      end else if (!wr_sync_ff[1]) begin
         wr_ack_ff <= 1'b0;
      end
   end

   dbfc_buf #(
      .W     (1),
      .DEPTH (BUF_DEPTH)
   ) u_wbuf (
      .clk       (clk),
      .rstn      (rstn),
      .in_valid  (buf_in_valid),
      .in_ready  (buf_in_ready),
      .in_data   (wr_data),
      .out_valid (buf_out_valid),
      .out_ready (buf_out_ready),
      .out_data  (buf_out_data)
   );

   assign ptr_eq = (wptr_ff == rptr_ff);
   assign full   = ptr_eq && last_wr_ff;
   assign empty  = ptr_eq && !last_wr_ff;

   assign grant_ref = (st_ff == dbfc_pkg::ST_IDLE) && ref_pend_ff;
   assign grant_wr  = (st_ff == dbfc_pkg::ST_IDLE) && !ref_pend_ff &&
                      buf_out_valid && !full;
   assign grant_rd  = (st_ff == dbfc_pkg::ST_IDLE) && !ref_pend_ff &&
                      !grant_wr && rd_sync_ff[1] && !rd_ack_ff &&
                      !rd_busy_ff && !empty;

   assign pc_done  = (pc_ff == 4'h0);
   assign step_col = (st_ff == dbfc_pkg::ST_ROW) && pc_done;
   assign buf_out_ready = step_col && act_wr_ff;

   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         dbfc_pkg::ST_IDLE: begin
            if (grant_ref) begin
               nxt_st = dbfc_pkg::ST_RCAS;
            end else if (grant_wr || grant_rd) begin
               nxt_st = dbfc_pkg::ST_ROW;
            end
         end
         dbfc_pkg::ST_ROW: begin
            if (pc_done) nxt_st = dbfc_pkg::ST_COL;
         end
         dbfc_pkg::ST_COL: begin
            if (pc_done) nxt_st = dbfc_pkg::ST_PRE;
         end
         dbfc_pkg::ST_RCAS: begin
            if (pc_done) nxt_st = dbfc_pkg::ST_RRAS;
         end
         dbfc_pkg::ST_RRAS: begin
            if (pc_done) nxt_st = dbfc_pkg::ST_PRE;
         end
         dbfc_pkg::ST_PRE: begin
            if (pc_done) nxt_st = dbfc_pkg::ST_IDLE;
         end
         default: nxt_st = dbfc_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= dbfc_pkg::ST_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // phase timer reloads on every state change
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pc_ff <= 4'h0;
      end else if (nxt_st != st_ff) begin
         pc_ff <= 4'(PHASE_CYC - 1);
      end else if (!pc_done) begin
         pc_ff <= pc_ff - 4'h1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         act_wr_ff <= 1'b0;
      end else if (grant_wr || grant_rd) begin
         act_wr_ff <= grant_wr;
      end
   end

   assign act_ptr   = act_wr_ff ? wptr_ff : rptr_ff;
   assign act_shift = {act_ptr[PTR_W-2:0],
                       act_ptr[`DBFC_TAP_HI] ^ act_ptr[`DBFC_TAP_LO]};

   always_comb begin
      row_addr = '0;
      col_addr = '0;
      for (int i = 0; i < ADDR_W; i++) begin
         row_addr[i] = (grant_wr ? wptr_ff[2*i] : rptr_ff[2*i]);
         col_addr[i] = act_shift[2*i];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wptr_ff    <= `DBFC_SEED;
         rptr_ff    <= `DBFC_SEED;
         last_wr_ff <= 1'b0;
      end else if (step_col) begin
         if (act_wr_ff) begin
            wptr_ff <= act_shift;
         end else begin
            rptr_ff <= act_shift;
         end
         last_wr_ff <= act_wr_ff;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         addr_ff   <= '0;
         ras_n_ff  <= 1'b1;
         cas_n_ff  <= 1'b1;
         we_n_ff   <= 1'b1;
         dram_d_ff <= 1'b0;
      end else begin
         case (nxt_st)
            dbfc_pkg::ST_ROW: begin
               if (st_ff == dbfc_pkg::ST_IDLE) addr_ff <= row_addr;
               ras_n_ff <= 1'b0;
            end
            dbfc_pkg::ST_COL: begin
               if (step_col) begin
                  addr_ff   <= col_addr;
                  we_n_ff   <= !act_wr_ff;
                  dram_d_ff <= act_wr_ff ? buf_out_data : 1'b0;
               end
               cas_n_ff <= 1'b0;
            end
            dbfc_pkg::ST_RCAS: begin
               cas_n_ff <= 1'b0;
               we_n_ff  <= 1'b1;
            end
            dbfc_pkg::ST_RRAS: begin
               ras_n_ff <= 1'b0;
            end
            default: begin
               ras_n_ff <= 1'b1;
               cas_n_ff <= 1'b1;
               we_n_ff  <= 1'b1;
            end
         endcase
      end
   end

   // read handshake; data captured at end of the column phase
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_busy_ff <= 1'b0;
         rd_ack_ff  <= 1'b0;
         rd_data_ff <= 1'b0;
      end else begin
         if (grant_rd) begin
            rd_busy_ff <= 1'b1;
         end else if (st_ff == dbfc_pkg::ST_COL && pc_done &&
                      rd_busy_ff) begin
            rd_busy_ff <= 1'b0;
            rd_ack_ff  <= 1'b1;
            rd_data_ff <= dram_q;
         end else if (!rd_sync_ff[1]) begin
            rd_ack_ff <= 1'b0;
         end
      end
   end

   // refresh timer, set wins over clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ref_cnt_ff  <= 12'h000;
         ref_pend_ff <= 1'b0;
      end else begin
         if (ref_cnt_ff == 12'(REF_CYC - 1)) begin
            ref_cnt_ff  <= 12'h000;
            ref_pend_ff <= 1'b1;
         end else begin
            ref_cnt_ff <= ref_cnt_ff + 12'h001;
            if (grant_ref) ref_pend_ff <= 1'b0;
         end
      end
   end

   assign wr_ack    = wr_ack_ff;
   assign rd_ack    = rd_ack_ff;
   assign rd_data   = rd_data_ff;
   assign dram_addr = addr_ff;
   assign ras_n     = ras_n_ff;
   assign cas_n     = cas_n_ff;
   assign we_n      = we_n_ff;
   assign dram_d    = dram_d_ff;
endmodule : dbfc_top

// File: bench/dbfc_monitor.sv
// Purpose: port checker of the DRAM-backed FIFO controller
// Assumes: PHASE_CYC of 3
// Notes:   bound to every dbfc_top
`timescale 1ns/1ns
module dbfc_monitor #(
   parameter int REF_CYC = 16
) (
   input wire logic clk,     // clock
   input wire logic rstn,    // reset, active low
   input wire logic wr_req,  // write request
   input wire logic wr_ack,  // write taken
   input wire logic rd_req,  // read request
   input wire logic rd_ack,  // read done
   input wire logic rd_data, // read bit
   input wire logic full,    // fifo full
   input wire logic empty,   // fifo empty
   input wire logic ras_n,   // row strobe
   input wire logic cas_n,   // column strobe
   input wire logic we_n     // write enable
);
   logic [15:0] gap_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // cycles since the CAS-only phase of the last refresh ended
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) gap_ff <= 16'h0;
      else if (!cas_n && ras_n) gap_ff <= 16'h0;
      else gap_ff <= gap_ff + 16'h1;
   end

   a_flags_apart: assert property (!(full && empty))
      else $error("full and empty together");
   a_rst_empty: assert property ($rose(rstn) |-> empty && !full)
      else $error("not empty after reset");
   a_no_wr_full: assert property (
      $fell(cas_n) && !ras_n && !we_n |-> !$past(full))
      else $error("write while full");
   a_no_rd_empty: assert property (
      $fell(cas_n) && !ras_n && we_n |-> !$past(empty))
      else $error("read while empty");
   a_row_col: assert property ($fell(ras_n) && cas_n |->
      (!ras_n && cas_n)[*3] ##1 (!ras_n && !cas_n))
      else $error("row phase length");
   a_cbr_order: assert property ($fell(cas_n) && ras_n |->
      (ras_n && !cas_n)[*3] ##1 (!ras_n && !cas_n))
      else $error("refresh strobe order");
   a_pre_gap: assert property ($rose(ras_n) |-> (ras_n && cas_n)[*3])
      else $error("precharge too short");
   a_we_in_cyc: assert property (!we_n |-> !ras_n)
      else $error("write enable outside access");
   a_ref_period: assert property (gap_ff <= 16'(REF_CYC + 24))
      else $error("refresh overdue");
   a_wr_sync: assert property ($rose(wr_ack) |-> $past(wr_req, 2))
      else $error("write ack without request");
   a_rd_stand: assert property (rd_ack && rd_req |=>
      rd_ack && $stable(rd_data))
      else $error("read answer dropped early");
endmodule : dbfc_monitor

bind dbfc_top dbfc_monitor #(.REF_CYC(REF_CYC)) i_mon (
   .clk(clk), .rstn(rstn), .wr_req(wr_req), .wr_ack(wr_ack),
   .rd_req(rd_req), .rd_ack(rd_ack), .rd_data(rd_data), .full(full),
   .empty(empty), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n));

// File: bench/dbfc_dram_model.sv
// Purpose: behavioural single-port one-bit DRAM
// Assumes: address and strobes change together on the clock edge
// Notes:   output shows the inverse of the last bit when released
`timescale 1ns/1ns
module dbfc_dram_model (
   input  wire logic [9:0] addr,  // row or column address
   input  wire logic       ras_n, // row strobe
   input  wire logic       cas_n, // column strobe
   input  wire logic       we_n,  // write enable
   input  wire logic       d,     // bit to store
   output logic            q      // bit read
);
   logic       mem [bit [19:0]];
   logic [9:0] row;
   logic       last;

   initial begin
      q = 1'b0;
      last = 1'b0;
      row = 10'h0;
   end
   always @(negedge ras_n) begin
      #1 if (cas_n) row = addr;
   end
   always @(negedge cas_n) begin
      #1 if (!ras_n && !we_n) mem[{row, addr}] = d;
      if (!ras_n && we_n) begin
         last = mem.exists({row, addr}) ? mem[{row, addr}] : 1'bx;
         q = last;
      end
   end
   always @(posedge cas_n) q = ~last;
endmodule : dbfc_dram_model

// File: bench/tb_top.sv
// Purpose: self-checking bench of the DRAM-backed FIFO controller
// Assumes: short refresh interval of 16 cycles
// Notes:   address order is tracked beside the memory model
`timescale 1ns/1ns
`include "dbfc_cfg.svh"
module tb_top;
   logic        clk, rstn, wr_req, wr_data, rd_req, dram_q;
   logic        wr_ack, rd_ack, rd_data, full, empty;
   logic        ras_n, cas_n, we_n, dram_d, ras_q, cas_q;
   logic [9:0]  dram_addr, row_q;
   logic [19:0] wp, rp, p;
   int          error_cnt, checked, ref_cnt, r0;

   dbfc_top #(.REF_CYC(16)) i_dut (.clk(clk), .rstn(rstn),
      .wr_req(wr_req), .wr_data(wr_data), .wr_ack(wr_ack),
      .rd_req(rd_req), .rd_ack(rd_ack), .rd_data(rd_data),
      .full(full), .empty(empty), .dram_addr(dram_addr), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .dram_d(dram_d), .dram_q(dram_q));
   dbfc_dram_model i_dram (.addr(dram_addr), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .d(dram_d), .q(dram_q));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   function automatic logic [19:0] nxt(input logic [19:0] v);
      return {v[18:0], v[19] ^ v[16]};
   endfunction : nxt
   function automatic logic [9:0] evn(input logic [19:0] v);
      for (int i = 0; i < 10; i++) evn[i] = v[2*i];
   endfunction : evn

   task automatic chk(input logic [19:0] g, input logic [19:0] e);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask : chk

   task print_verdict;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : print_verdict

   task automatic wait_ack(input bit rd, input logic v);
      int n;
      n = 0;
      while (((rd ? rd_ack : wr_ack) !== v) && n < 400) begin
         @(negedge clk);
         n++;
      end
      if ((rd ? rd_ack : wr_ack) !== v) begin
         error_cnt++;
         $display("unexpected at %0t: ack %h exp %h", $time, ~v, v);
         print_verdict;
      end
   endtask : wait_ack

   task automatic wr_bit(input logic b);
      @(negedge clk);
      wr_data = b;
      wr_req = 1'b1;
      wait_ack(1'b0, 1'b1);
      wr_req = 1'b0;
      wait_ack(1'b0, 1'b0);
   endtask : wr_bit

   task automatic rd_bit(input logic b);
      @(negedge clk);
      rd_req = 1'b1;
      wait_ack(1'b1, 1'b1);
      chk(20'(rd_data), 20'(b));
      // hold the request one more cycle: the answer must stand
      @(negedge clk);
      chk(20'({rd_ack, rd_data}), 20'({1'b1, b}));
      rd_req = 1'b0;
      wait_ack(1'b1, 1'b0);
   endtask : rd_bit

   // address order seen on the memory strobes
   always @(negedge clk) begin
      if (rstn && ras_q && !ras_n && cas_n) row_q = dram_addr;
      if (rstn && cas_q && !cas_n && ras_n) ref_cnt++;
      if (rstn && cas_q && !cas_n && !ras_n) begin
         p = we_n ? rp : wp;
         chk(20'(row_q), 20'(evn(p)));
         chk(20'(dram_addr), 20'(evn(nxt(p))));
         if (we_n) rp = nxt(rp);
         else wp = nxt(wp);
      end
      ras_q = ras_n;
      cas_q = cas_n;
   end

   task automatic t_reset;
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      wp = `DBFC_SEED;
      rp = `DBFC_SEED;
      rstn = 1'b1;
      chk(20'({empty, full}), 20'h2);
      chk(20'({ras_n, cas_n, we_n}), 20'h7);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_order;
      logic [5:0] pat;
      pat = 6'h2D;
      for (int i = 0; i < 6; i++) wr_bit(pat[i]);
      chk(20'({empty, full}), 20'h0);
      for (int i = 0; i < 6; i++) rd_bit(pat[i]);
      repeat (4) @(negedge clk);
      chk(20'({empty, full}), 20'h2);
      $display("t_order done");
   endtask : t_order

   task automatic t_empty_read;
      @(negedge clk);
      rd_req = 1'b1;
      repeat (40) @(negedge clk);
      chk(20'(rd_ack), 20'h0);
      wr_bit(1'b1);
      wait_ack(1'b1, 1'b1);
      chk(20'(rd_data), 20'h1);
      rd_req = 1'b0;
      wait_ack(1'b1, 1'b0);
      chk(20'(empty), 20'h1);
      $display("t_empty_read done");
   endtask : t_empty_read

   task automatic t_refresh;
      r0 = ref_cnt;
      repeat (60) @(negedge clk);
      chk(20'(ref_cnt - r0 >= 3), 20'h1);
      wr_bit(1'b0);
      rd_bit(1'b0);
      $display("t_refresh done");
   endtask : t_refresh

   initial begin
      rstn = 1'b0;
      wr_req = 1'b0;
      wr_data = 1'b0;
      rd_req = 1'b0;
      ras_q = 1'b1;
      cas_q = 1'b1;
      row_q = 10'h0;
      p = 20'h0;
      wp = `DBFC_SEED;
      rp = `DBFC_SEED;
      error_cnt = 0;
      checked = 0;
      ref_cnt = 0;
      t_reset;
      t_order;
      t_empty_read;
      t_refresh;
      wr_bit(1'b1);
      t_reset;
      t_order;
      print_verdict;
   end
endmodule : tb_top
